// ---- src/pin_channel_control_regs.sv ----
// Purpose: per-channel drive/load and measurement unit control registers
// Assumes: serial port front end delivers a decoded write/read strobe per word
// Notes: two channels selected by chan_sel_i; outputs registered
// ==========================================================
// Summary of operation
// R1: force state field picks low, high, termination
// R2: force bit chooses forced state over inputs
// R3: force yields to enable, beats term select
// R4: force load turns load on and connected
// R5: force load yields to enable, beats load enable
// R6: disabled channel goes to low-leakage state
// R7: channel enable overrides drive and load, not pulldown or measurement unit controls
// R8: power bit switches measurement unit power
// R9: power on forces max hysteresis, registers kept
// R10: sense enable bit closes sense switch
// R11: clamp bit enables measurement unit clamps
// R12: sense path bit picks external path
// R13: input source field picks ground, offset, dac
// R14: measure mode bit picks current measure
// R15: term select chooses termination or float
// R16: each channel keeps independent register copies
// R17: reserved bits ignore writes, read zero
`timescale 1ns/1ps
`include "pin_ctrl_consts.svh"
module pin_channel_control_regs (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic chan_sel_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] drive_data_input_i,
  input wire logic [1:0] receive_select_input_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic [3:0] drv_level_o,
  output logic [1:0] load_on_o,
  output logic [1:0] chan_active_o,
  output logic [1:0] pin_soft_pulldown_o,
  output logic [1:0] meas_unit_power_o,
  output logic [1:0] hyst_force_max_o,
  output logic [1:0] external_sense_switch_o,
  output logic [1:0] meas_unit_clamp_enable_o,
  output logic [1:0] sense_path_select_o,
  output logic [3:0] meas_input_source_o,
  output logic [1:0] measure_mode_select_o
);
  logic [15:0] dlc_r [2];
  logic [15:0] puc_r [2];
  logic [15:0] rdata_nxt;

  // ==========================================================
  // per-channel register copies and decode
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    chan_ctrl_if cif ();
    pin_ctrl_pkg::drv_level_type lvl;
    logic load_on;
    logic active;
    pin_ctrl_pkg::meas_src_type src;

    // only the addressed channel's copy changes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        dlc_r[ch] <= `DLC_RESET;
      end else if (wr_en_i && chan_sel_i == 1'(ch) && addr_i == `DLC_ADDR) begin
        dlc_r[ch] <= wdata_i & `DLC_WMASK; // see R16
      end
    end

    // reserved bits masked so they never store
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        puc_r[ch] <= `PUC_RESET;
      end else if (wr_en_i && chan_sel_i == 1'(ch) && addr_i == `PUC_ADDR) begin
        puc_r[ch] <= wdata_i & `PUC_WMASK; // see R16 see R17
      end
    end

    assign cif.dlc = dlc_r[ch];
    assign cif.puc = puc_r[ch];

    chan_decode u_dec (
      .ctl(cif.dec),
      .drive_data_input_i(drive_data_input_i[ch]),
      .receive_select_input_i(receive_select_input_i[ch]),
      .drv_level_o(lvl),
      .load_on_o(load_on),
      .chan_active_o(active),
      .src_o(src)
    );

    // registered analog controls; pulldown ignores channel enable
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        drv_level_o[2*ch +: 2] <= 2'h3;
        load_on_o[ch] <= 1'b0;
        chan_active_o[ch] <= 1'b0;
        pin_soft_pulldown_o[ch] <= 1'b0;
      end else begin
        drv_level_o[2*ch +: 2] <= lvl; // see R1 see R2 see R3 see R15
        load_on_o[ch] <= load_on; // see R4 see R5
        chan_active_o[ch] <= active; // see R6 see R7
        pin_soft_pulldown_o[ch] <= dlc_r[ch][`DLC_PULLDN_BIT]; // see R7
      end
    end

    // measurement unit controls
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        meas_unit_power_o[ch] <= 1'b0;
        hyst_force_max_o[ch] <= 1'b0;
        external_sense_switch_o[ch] <= 1'b0;
        meas_unit_clamp_enable_o[ch] <= 1'b0;
        sense_path_select_o[ch] <= 1'b0;
        meas_input_source_o[2*ch +: 2] <= 2'h0;
        measure_mode_select_o[ch] <= 1'b0;
      end else begin
        meas_unit_power_o[ch] <= puc_r[ch][`PUC_POWER_BIT]; // see R8
        // override only; hysteresis registers elsewhere untouched
        hyst_force_max_o[ch] <= puc_r[ch][`PUC_POWER_BIT]; // see R9
        external_sense_switch_o[ch] <= puc_r[ch][`PUC_XSENSE_BIT]; // see R10
        meas_unit_clamp_enable_o[ch] <= puc_r[ch][`PUC_CLAMP_BIT]; // see R11
        sense_path_select_o[ch] <= puc_r[ch][`PUC_SPATH_BIT]; // see R12
        meas_input_source_o[2*ch +: 2] <= src; // see R13
        measure_mode_select_o[ch] <= puc_r[ch][`PUC_MEAS_BIT]; // see R14
      end
    end
  end

  // ==========================================================
  // read-back mux; unmapped addresses read zero
  always_comb begin
    if (addr_i == `DLC_ADDR) begin
      rdata_nxt = chan_sel_i ? dlc_r[1] : dlc_r[0];
    end else if (addr_i == `PUC_ADDR) begin
      rdata_nxt = chan_sel_i ? puc_r[1] : puc_r[0]; // see R17
    end else begin
      rdata_nxt = 16'h0000;
    end
  end

  // read data held until next read
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 16'h0000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_en_i;
      if (rd_en_i) begin
        rdata_o <= rdata_nxt;
      end
    end
  end
endmodule : pin_channel_control_regs

// ---- src/pin_ctrl_consts.svh ----
// Purpose: offsets, field positions and reset values of the channel control registers
// Assumes: 16-bit data words, 5-bit register addresses on the serial port
// Notes: included by bare name
`ifndef PIN_CTRL_CONSTS_SVH
`define PIN_CTRL_CONSTS_SVH

// ==========================================================
// register addresses
`define DLC_ADDR 5'h19
`define PUC_ADDR 5'h1a

// ==========================================================
// drive/load control fields
`define DLC_CH_EN_BIT 0
`define DLC_FDRV_BIT 1
`define DLC_FLOAD_BIT 2
`define DLC_FSTATE_LO 3
`define DLC_FSTATE_HI 4
`define DLC_LOAD_EN_BIT 5
`define DLC_TERM_HIZ_BIT 6
`define DLC_PULLDN_BIT 7
`define DLC_WMASK 16'h00ff
`define DLC_RESET 16'h0000

// ==========================================================
// measurement unit control fields
`define PUC_MEAS_BIT 5
`define PUC_SRC_LO 6
`define PUC_SRC_HI 7
`define PUC_SPATH_BIT 8
`define PUC_CLAMP_BIT 9
`define PUC_XSENSE_BIT 11
`define PUC_POWER_BIT 15
`define PUC_WMASK 16'h8be0
`define PUC_RESET 16'h0000

`endif

// ---- src/pin_ctrl_pkg.sv ----
// Purpose: shared types of the channel control registers
// Assumes: constants live in pin_ctrl_consts.svh
// Notes: nothing here is imported
package pin_ctrl_pkg;
  // driver output level
  typedef enum logic [1:0] {
    drv_low_type_val = 2'b00,
    drv_high_type_val = 2'b01,
    drv_term_type_val = 2'b10,
    drv_hiz_type_val = 2'b11
  } drv_level_type;

  // measurement input source
  typedef enum logic [1:0] {
    src_gnd_type_val = 2'b00,
    src_gnd_ofs_type_val = 2'b01,
    src_dac_type_val = 2'b10
  } meas_src_type;
endpackage : pin_ctrl_pkg

// ---- src/chan_ctrl_if.sv ----
// Purpose: carries one channel's two control words to the decode module
// Assumes: single clock domain
// Notes: regs modport drives words, dec modport reads them
`timescale 1ns/1ps
interface chan_ctrl_if;
  logic [15:0] dlc;
  logic [15:0] puc;
  modport regs (output dlc, output puc);
  modport dec (input dlc, input puc);
endinterface : chan_ctrl_if

// ---- src/chan_decode.sv ----
// Purpose: turns one channel's control words into driver, load and meas input source controls
// Assumes: words are stable register outputs
// Notes: purely combinational; the top registers the results
`timescale 1ns/1ps
`include "pin_ctrl_consts.svh"
module chan_decode (
  chan_ctrl_if.dec ctl,
  input wire logic drive_data_input_i,
  input wire logic receive_select_input_i,
  output pin_ctrl_pkg::drv_level_type drv_level_o,
  output logic load_on_o,
  output logic chan_active_o,
  output pin_ctrl_pkg::meas_src_type src_o
);
  // ==========================================================
  // driver precedence: enable, then force, then receive/data
  always_comb begin
    chan_active_o = ctl.dlc[`DLC_CH_EN_BIT]; // see R6
    if (!ctl.dlc[`DLC_CH_EN_BIT]) begin
      drv_level_o = pin_ctrl_pkg::drv_hiz_type_val; // see R7 see R3
    end else if (ctl.dlc[`DLC_FDRV_BIT]) begin
      case (ctl.dlc[`DLC_FSTATE_HI:`DLC_FSTATE_LO]) // see R1 see R2
        2'b00: drv_level_o = pin_ctrl_pkg::drv_low_type_val;
        2'b11: drv_level_o = pin_ctrl_pkg::drv_term_type_val;
        default: drv_level_o = pin_ctrl_pkg::drv_high_type_val;
      endcase
    end else if (receive_select_input_i) begin
      // receive: terminate or float
      drv_level_o = ctl.dlc[`DLC_TERM_HIZ_BIT] ? pin_ctrl_pkg::drv_term_type_val
                                               : pin_ctrl_pkg::drv_hiz_type_val; // see R15
    end else begin
      drv_level_o = drive_data_input_i ? pin_ctrl_pkg::drv_high_type_val
                                       : pin_ctrl_pkg::drv_low_type_val; // see R2
    end
  end

  // ==========================================================
  // load: disabled channel wins, force beats enable and receive
  always_comb begin
    if (!ctl.dlc[`DLC_CH_EN_BIT]) begin
      load_on_o = 1'b0; // see R5 see R7
    end else if (ctl.dlc[`DLC_FLOAD_BIT]) begin
      load_on_o = 1'b1; // see R4 see R5
    end else begin
      load_on_o = ctl.dlc[`DLC_LOAD_EN_BIT] & receive_select_input_i; // see R4
    end
  end

  // ==========================================================
  // input source: 1x means level dac
  always_comb begin
    if (ctl.puc[`PUC_SRC_HI]) begin
      src_o = pin_ctrl_pkg::src_dac_type_val; // see R13
    end else if (ctl.puc[`PUC_SRC_LO]) begin
      src_o = pin_ctrl_pkg::src_gnd_ofs_type_val;
    end else begin
      src_o = pin_ctrl_pkg::src_gnd_type_val;
    end
  end
endmodule : chan_decode

// ---- test/pin_ctrl_properties.sv ----
// Purpose: port checks for the channel control registers
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to the top module below
`timescale 1ns/1ps
module pin_ctrl_properties (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic chan_sel_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [3:0] drv_level_o,
  input wire logic [1:0] load_on_o,
  input wire logic [1:0] chan_active_o,
  input wire logic [1:0] pin_soft_pulldown_o,
  input wire logic [1:0] meas_unit_power_o,
  input wire logic [1:0] hyst_force_max_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================================
  // read port
  chk_read_answer: assert property (rd_en_i |=> rvalid_o)
    else $error("read not answered");
  chk_meas_reserved: assert property (
    rvalid_o && $past(addr_i) == 5'h1a |-> (rdata_o & 16'h741f) == 16'h0000)
    else $error("reserved bits read nonzero");
  chk_unmapped_zero: assert property (
    rvalid_o && !($past(addr_i) inside {5'h19, 5'h1a}) |-> rdata_o == 16'h0000)
    else $error("unmapped read nonzero");
  // ==========================================================
  // control outputs; writes land two edges on
  chk_ch0_disabled: assert property (
    !chan_active_o[0] |-> drv_level_o[1:0] == 2'h3 && !load_on_o[0])
    else $error("disabled channel 0 not off");
  chk_ch1_disabled: assert property (
    !chan_active_o[1] |-> drv_level_o[3:2] == 2'h3 && !load_on_o[1])
    else $error("disabled channel 1 not off");
  chk_hyst_power: assert property (hyst_force_max_o == meas_unit_power_o)
    else $error("hysteresis force differs from power");
  chk_enable_write: assert property (
    wr_en_i && addr_i == 5'h19 && !chan_sel_i |-> ##2 chan_active_o[0] == $past(wdata_i[0], 2))
    else $error("enable write not applied");
  chk_pulldown_write: assert property (
    wr_en_i && addr_i == 5'h19 && chan_sel_i |-> ##2 pin_soft_pulldown_o[1] == $past(wdata_i[7], 2))
    else $error("pulldown write not applied");
  chk_power_write: assert property (
    wr_en_i && addr_i == 5'h1a && chan_sel_i |-> ##2 meas_unit_power_o[1] == $past(wdata_i[15], 2))
    else $error("power write not applied");
  cover property (rvalid_o);
  cover property (wr_en_i && addr_i == 5'h1a);
  cover property (chan_active_o == 2'h3);
endmodule : pin_ctrl_properties
bind pin_channel_control_regs pin_ctrl_properties pin_ctrl_properties_inst (.clk_i, .arst_n_i,
  .wr_en_i, .rd_en_i, .chan_sel_i, .addr_i, .wdata_i, .rdata_o, .rvalid_o, .drv_level_o,
  .load_on_o, .chan_active_o, .pin_soft_pulldown_o, .meas_unit_power_o, .hyst_force_max_o);

// ---- test/host_model.sv ----
// Purpose: host side of the register port
// Assumes: tasks entered at a falling edge
// Notes: address and data lines are flipped after use so stale values never look valid
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic [15:0] rdata_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic chan_sel_o,
  output logic [4:0] addr_o,
  output logic [15:0] wdata_o
);
  initial begin
    {wr_en_o, rd_en_o, chan_sel_o, addr_o, wdata_o} = '0;
  end
  // idle edge first, so a strobe never drops and rises in one step
  task automatic wr_word(input logic c, input logic [4:0] ad, input logic [15:0] v);
    @(negedge clk_i);
    {chan_sel_o, addr_o, wdata_o, wr_en_o} = {c, ad, v, 1'b1};
    @(negedge clk_i);
    {wr_en_o, addr_o, wdata_o} = {1'b0, ~ad, ~v};
  endtask : wr_word
  // answer is due one edge after the strobe
  task automatic rd_word(input logic c, input logic [4:0] ad, output logic [15:0] d,
                         output logic ok);
    @(negedge clk_i);
    {chan_sel_o, addr_o, rd_en_o} = {c, ad, 1'b1};
    @(negedge clk_i);
    {rd_en_o, addr_o} = {1'b0, ~ad};
    ok = rvalid_i;
    d = rdata_i;
  endtask : rd_word
endmodule : host_model

// ---- test/testbench.sv ----
// Purpose: self-checking bench of the channel control registers
// Assumes: outputs settle two edges after a write
// Notes: shadow words mirror what each write should store
`timescale 1ns/1ps
module testbench;
  logic clk_i, arst_n_i, wr_en_i, rd_en_i, chan_sel_i, rvalid_o, ok;
  logic [4:0] addr_i;
  logic [15:0] wdata_i, rdata_o, d, r;
  logic [1:0] drive_data_input_i, receive_select_input_i, load_on_o, chan_active_o;
  logic [1:0] pin_soft_pulldown_o, meas_unit_power_o, hyst_force_max_o, measure_mode_select_o;
  logic [1:0] external_sense_switch_o, meas_unit_clamp_enable_o, sense_path_select_o;
  logic [3:0] drv_level_o, meas_input_source_o;
  logic [15:0] dlc [2];
  logic [15:0] puc [2];
  int seed = 33607;
  int n_mismatch = 0;
  int compares = 0;
  pin_channel_control_regs pin_channel_control_regs_inst (.clk_i, .arst_n_i, .wr_en_i,
    .rd_en_i, .chan_sel_i, .addr_i, .wdata_i, .drive_data_input_i, .receive_select_input_i,
    .rdata_o, .rvalid_o, .drv_level_o, .load_on_o, .chan_active_o, .pin_soft_pulldown_o,
    .meas_unit_power_o, .hyst_force_max_o, .external_sense_switch_o,
    .meas_unit_clamp_enable_o, .sense_path_select_o, .meas_input_source_o,
    .measure_mode_select_o);
  host_model host_model_inst (.clk_i, .rvalid_i(rvalid_o), .rdata_i(rdata_o),
    .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .chan_sel_o(chan_sel_i), .addr_o(addr_i),
    .wdata_o(wdata_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // precedence: enable, then force, then receive select, then data
  function automatic logic [1:0] exp_lvl(input logic [15:0] w, input logic dt, input logic rc);
    if (!w[0]) return 2'h3;
    if (w[1]) return (w[4:3] == 2'h0) ? 2'h0 : (w[4:3] == 2'h3) ? 2'h2 : 2'h1;
    if (rc) return w[6] ? 2'h2 : 2'h3;
    return {1'b0, dt};
  endfunction : exp_lvl
  task automatic check_all();
    repeat (3) @(negedge clk_i);
    for (int c = 0; c < 2; c++) begin
      chk("level", 16'(drv_level_o[2*c+:2]),
        16'(exp_lvl(dlc[c], drive_data_input_i[c], receive_select_input_i[c])));
      chk("load", 16'(load_on_o[c]),
        16'(dlc[c][0] & (dlc[c][2] | dlc[c][5] & receive_select_input_i[c])));
      chk("enable pulldown", 16'({chan_active_o[c], pin_soft_pulldown_o[c]}),
        16'({dlc[c][0], dlc[c][7]}));
      chk("meas", 16'({meas_unit_power_o[c], hyst_force_max_o[c],
        external_sense_switch_o[c], meas_unit_clamp_enable_o[c], sense_path_select_o[c],
        measure_mode_select_o[c]}), 16'({puc[c][15], puc[c][15], puc[c][11], puc[c][9:8],
        puc[c][5]}));
      chk("source", 16'(meas_input_source_o[2*c+:2]),
        16'(puc[c][7] ? 2'h2 : {1'b0, puc[c][6]}));
    end
  endtask : check_all
  // write, mirror, settle, compare, read back
  task automatic put(input logic c, input logic [4:0] ad, input logic [15:0] v);
    host_model_inst.wr_word(c, ad, v);
    if (ad == 5'h19) dlc[c] = v & 16'h00ff;
    if (ad == 5'h1a) puc[c] = v & 16'h8be0;
    drive_data_input_i = 2'($random(seed));
    receive_select_input_i = 2'($random(seed));
    check_all();
    host_model_inst.rd_word(c, ad, d, ok);
    chk("rvalid", 16'(ok), 16'h0001);
    chk("readback", d, (ad == 5'h19) ? dlc[c] : (ad == 5'h1a) ? puc[c] : 16'h0000);
  endtask : put
  initial begin
    arst_n_i = 1'b0;
    drive_data_input_i = 2'h0;
    receive_select_input_i = 2'h0;
    dlc = '{16'h0000, 16'h0000};
    puc = '{16'h0000, 16'h0000};
    repeat (10) @(negedge clk_i);
    arst_n_i = 1'b1;
    check_all();
    $display("test reset done");
    // every forced state code, then force with channel off, then an unmapped word
    for (int k = 0; k < 4; k++) put(1'(k), 5'h19, 16'h0063 | 16'(k << 3));
    put(1'b0, 5'h19, 16'h00fe);
    put(1'b1, 5'h05, 16'hffff);
    put(1'b1, 5'h1a, 16'hffff);
    $display("test corners done");
    repeat (60) begin
      r = 16'($random(seed));
      put(r[0], r[1] ? 5'h19 : 5'h1a, 16'($random(seed)));
    end
    $display("test random done");
    // reset again with live settings; every output must fall back to its idle value
    arst_n_i = 1'b0;
    dlc = '{16'h0000, 16'h0000};
    puc = '{16'h0000, 16'h0000};
    repeat (2) @(negedge clk_i);
    arst_n_i = 1'b1;
    check_all();
    $display("test mid reset done");
    print_verdict();
  end
endmodule : testbench
